// file: hdl/sqrt_float_convert_unit.sv
// The plain strobed port and the register addresses were decided locally.
`default_nettype none
module sqrt_float_convert_unit (
  input wire logic clk_sys_in,                  // system clock, 125 MHz
  input wire logic sys_rst_in,                  // synchronous reset, high
  input wire logic req_valid_in,                // request from sequencer
  output logic req_ready_out,                   // unit idle, request taken
  input wire fpconv_pkg::req_s req_in,          // operation and operands
  output logic done_out,                        // one-cycle completion
  output fpconv_pkg::result_s result_out,       // destination words
  output fpconv_pkg::flags_s flags_out,         // status flags
  output logic [15:0] error_code_register_out,  // last error code
  input wire logic [7:0] reg_addr_in,           // register byte address
  input wire logic [31:0] reg_wdata_in,         // register write data
  input wire logic reg_wr_in,                   // register write strobe
  input wire logic reg_rd_in,                   // register read strobe
  output logic [31:0] reg_rdata_out,            // read data, next cycle
  output logic irq_out                          // level interrupt
);
  import fpconv_pkg::*;

  state_e state, next_state;
  result_s result, next_result;
  flags_s flags, next_flags;
  logic [15:0] err_code, next_err_code;
  logic done, next_done;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] rdata, next_rdata;

  logic root_start;
  logic root_done;
  logic [15:0] root_val;
  logic [31:0] root_rad;
  logic root_neg;

  // integer to float
  logic [31:0] int_val;
  logic [31:0] int_mag;
  logic int_neg;
  logic [4:0] msb;
  logic [31:0] norm;
  logic [8:0] i2f_exp;
  logic [31:0] i2f_word;
  logic i2f_zero;
  logic i2f_over;
  logic i2f_under;

  // float to integer
  logic [31:0] fl;
  logic [7:0] f_exp;
  logic [63:0] shifted;
  logic [32:0] f_mag;
  logic f_frac;
  logic f_big;
  logic f_small;
  logic f_sat;
  logic [32:0] lim_pos;
  logic [32:0] lim_neg;
  logic [31:0] f_ival;
  logic [31:0] f2i_word;

  logic wr_flags, wr_err, wr_irq, wr_mask;
  logic [IRQ_W-1:0] irq_events;

  sqrt_iter #(
    .RAD_W(ROOT_RAD_W)
  ) u_root (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .start_in(root_start),
    .radicand_in(root_rad),
    .done_out(root_done),
    .root_out(root_val)
  );

  assign root_rad = req_in.wide ? {req_in.src_hi, req_in.src_lo} : {16'h0000, req_in.src_lo};
  assign root_neg = req_in.wide ? req_in.src_hi[15] : req_in.src_lo[15];

  // low half word sits in the lower register of a pair
  always_comb begin
    int_val = req_in.wide ? {req_in.src_hi, req_in.src_lo}
                          : {{16{req_in.src_lo[15]}}, req_in.src_lo};
    int_neg = int_val[31];
    int_mag = int_neg ? (32'h0 - int_val) : int_val;
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (int_mag[i]) begin
        msb = 5'(i);
      end
    end
    norm = int_mag << (5'h1f - msb);
    i2f_exp = FLOAT_BIAS + {4'h0, msb};
    i2f_zero = (int_mag == 32'h0);
    i2f_over = !i2f_zero && (i2f_exp > FLOAT_EXP_MAX);
    i2f_under = !i2f_zero && (i2f_exp < FLOAT_EXP_MIN);
    // mantissa truncated toward zero
    i2f_word = i2f_zero ? 32'h0 : {int_neg, i2f_exp[7:0], norm[30:8]};
  end

  always_comb begin
    fl = {req_in.src_hi, req_in.src_lo};
    f_exp = fl[30:23];
    f_big = (f_exp > FLOAT_INT_EXP_TOP);
    f_small = (f_exp < FLOAT_INT_BIAS);
    shifted = {40'h0, 1'b1, fl[22:0]} << 6'(f_exp - FLOAT_INT_BIAS);
    if (f_small) begin
      f_mag = 33'h0;
      f_frac = (f_exp != 8'h00) || (fl[22:0] != 23'h0);
    end else begin
      f_mag = shifted[55:23];
      f_frac = (shifted[22:0] != 23'h0);
    end
    lim_pos = req_in.wide ? LIMIT_POS_WIDE : LIMIT_POS_NARROW;
    lim_neg = req_in.wide ? LIMIT_NEG_WIDE : LIMIT_NEG_NARROW;
    f_sat = f_big || (fl[31] ? (f_mag > lim_neg) : (f_mag > lim_pos));
    f_ival = fl[31] ? (32'h0 - f_mag[31:0]) : f_mag[31:0];
    if (f_sat) begin
      if (req_in.wide) begin
        f2i_word = fl[31] ? SAT_MIN_WIDE : SAT_MAX_WIDE;
      end else begin
        f2i_word = fl[31] ? SAT_MIN_NARROW : SAT_MAX_NARROW;
      end
    end else if (req_in.wide) begin
      f2i_word = f_ival;
    end else begin
      f2i_word = {16'h0000, f_ival[15:0]};
    end
  end

  always_comb begin
    wr_flags = reg_wr_in && (reg_addr_in == ADDR_FLAGS);
    wr_err = reg_wr_in && (reg_addr_in == ADDR_ERROR_CODE);
    wr_irq = reg_wr_in && (reg_addr_in == ADDR_IRQ_STATUS);
    wr_mask = reg_wr_in && (reg_addr_in == ADDR_IRQ_MASK);
  end

  // operation sequencing; hardware sets win over software clears
  always_comb begin
    next_state = state;
    next_result = result;
    next_flags = flags;
    next_err_code = err_code;
    next_done = 1'b0;
    root_start = 1'b0;
    if (wr_flags && reg_wdata_in[FLAG_LATCH_BIT]) begin
      next_flags.operation_error_latch = 1'b0;
    end
    if (wr_err) begin
      next_err_code = reg_wdata_in[15:0];
    end
    case (state)
      ST_IDLE: begin
        if (req_valid_in) begin
          next_done = 1'b1;
          next_flags.operation_error_flag = 1'b0;
          if (req_in.op == SQUARE_ROOT_OP) begin
            if (root_neg) begin
              next_flags.zero_flag = 1'b0;
              next_flags.borrow_underflow_flag = 1'b0;
              next_flags.carry_overflow_flag = 1'b0;
              next_flags.operation_error_flag = 1'b1;
              next_flags.operation_error_latch = 1'b1;
              next_err_code = ERROR_CODE_NEG_ROOT;
            end else begin
              next_done = 1'b0;
              root_start = 1'b1;
              next_state = ST_ROOT;
            end
          end else if (req_in.op == NUMBER_FORMAT_CONVERT_OP) begin
            if (req_in.conversion_direction_select) begin
              next_result = f2i_word;
              next_flags.carry_overflow_flag = f_sat;
              next_flags.borrow_underflow_flag = f_frac && !f_sat;
              next_flags.zero_flag = (f2i_word == 32'h0);
            end else begin
              next_result = i2f_word;
              next_flags.carry_overflow_flag = i2f_over;
              next_flags.borrow_underflow_flag = i2f_under;
              next_flags.zero_flag = i2f_zero;
            end
          end
        end
      end
      ST_ROOT: begin
        if (root_done) begin
          next_result = {16'h0000, root_val};
          next_flags.zero_flag = (root_val == 16'h0000);
          next_flags.borrow_underflow_flag = 1'b0;
          next_flags.carry_overflow_flag = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // interrupt status and register reads
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_DONE_BIT] = done;
    irq_events[IRQ_ERROR_BIT] = done && flags.operation_error_flag;
    irq_events[IRQ_CARRY_BIT] = done && flags.carry_overflow_flag;
    next_irq_status = irq_status;
    if (wr_irq) begin
      next_irq_status = irq_status & ~reg_wdata_in[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
    next_irq_mask = wr_mask ? reg_wdata_in[IRQ_W-1:0] : irq_mask;
    next_rdata = 32'h0;
    if (reg_rd_in) begin
      if (reg_addr_in == ADDR_FLAGS) begin
        next_rdata = {27'h0, flags};
      end else if (reg_addr_in == ADDR_ERROR_CODE) begin
        next_rdata = {16'h0000, err_code};
      end else if (reg_addr_in == ADDR_IRQ_STATUS) begin
        next_rdata = {29'h0, irq_status};
      end else if (reg_addr_in == ADDR_IRQ_MASK) begin
        next_rdata = {29'h0, irq_mask};
      end else if (reg_addr_in == ADDR_RESULT) begin
        next_rdata = result;
      end else begin
        next_rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      result <= '0;
      flags <= '0;
      err_code <= ERROR_CODE_RESET;
      done <= 1'b0;
      irq_status <= '0;
      irq_mask <= IRQ_MASK_RESET;
      rdata <= 32'h0;
    end else begin
      state <= next_state;
      result <= next_result;
      flags <= next_flags;
      err_code <= next_err_code;
      done <= next_done;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
    end
  end

  assign req_ready_out = (state == ST_IDLE);
  assign done_out = done;
  assign result_out = result;
  assign flags_out = flags;
  assign error_code_register_out = err_code;
  assign reg_rdata_out = rdata;
  assign irq_out = |(irq_status & irq_mask);
endmodule : sqrt_float_convert_unit
`default_nettype wire

// file: hdl/fpconv_pkg.sv
// Operation
// - square root of source written to destination
// - negative root source: error flags, fixed code
// - zero root result sets zero flag
// - direction low converts integer to float
// - float magnitude too large sets carry flag
// - float magnitude too small sets borrow flag
// - zero conversion result sets zero flag
// - direction high converts float to integer, truncating
// - out-of-range integer saturates, sets carry flag
// - discarded fraction sets borrow flag unless the result saturates
// - zero integer result sets zero flag
`default_nettype none
package fpconv_pkg;
  localparam int WORD_W = 16;
  localparam int ROOT_RAD_W = 32;
  localparam int ROOT_STEPS = ROOT_RAD_W / 2;

  localparam logic [15:0] ERROR_CODE_NEG_ROOT = 16'h0e1b;
  localparam logic [15:0] ERROR_CODE_RESET = 16'h0000;

  localparam logic [8:0] FLOAT_BIAS = 9'h07f;
  localparam logic [8:0] FLOAT_EXP_MAX = 9'h0fe;
  localparam logic [8:0] FLOAT_EXP_MIN = 9'h001;
  localparam logic [7:0] FLOAT_INT_BIAS = 8'h7f;
  localparam logic [7:0] FLOAT_INT_EXP_TOP = 8'h9e;

  localparam logic [32:0] LIMIT_POS_WIDE = 33'h0_7fff_ffff;
  localparam logic [32:0] LIMIT_NEG_WIDE = 33'h0_8000_0000;
  localparam logic [32:0] LIMIT_POS_NARROW = 33'h0_0000_7fff;
  localparam logic [32:0] LIMIT_NEG_NARROW = 33'h0_0000_8000;
  localparam logic [31:0] SAT_MAX_WIDE = 32'h7fff_ffff;
  localparam logic [31:0] SAT_MIN_WIDE = 32'h8000_0000;
  localparam logic [31:0] SAT_MAX_NARROW = 32'h0000_7fff;
  localparam logic [31:0] SAT_MIN_NARROW = 32'h0000_8000;

  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_ERROR_CODE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_RESULT = 8'h10;

  localparam int FLAG_LATCH_BIT = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERROR_BIT = 1;
  localparam int IRQ_CARRY_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  typedef enum logic [1:0] {
    SQUARE_ROOT_OP = 2'b01,
    NUMBER_FORMAT_CONVERT_OP = 2'b10
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ROOT = 2'b10
  } state_e;

  typedef struct packed {
    op_e op;
    logic wide;
    logic conversion_direction_select;
    logic [15:0] src_hi;
    logic [15:0] src_lo;
  } req_s;

  typedef struct packed {
    logic [15:0] dst_hi;
    logic [15:0] dst_lo;
  } result_s;

  typedef struct packed {
    logic operation_error_latch;
    logic operation_error_flag;
    logic carry_overflow_flag;
    logic borrow_underflow_flag;
    logic zero_flag;
  } flags_s;
endpackage : fpconv_pkg
`default_nettype wire

// file: hdl/sqrt_iter.sv
`default_nettype none
module sqrt_iter #(
  parameter int RAD_W = 32
) (
  input wire logic clk_sys_in,                 // system clock
  input wire logic sys_rst_in,                 // synchronous reset, high
  input wire logic start_in,                   // one-cycle start
  input wire logic [RAD_W-1:0] radicand_in,    // unsigned radicand
  output logic done_out,                       // one-cycle completion
  output logic [RAD_W/2-1:0] root_out          // truncated root
);
  localparam int ROOT_W = RAD_W / 2;
  localparam int CNT_W = $clog2(ROOT_W + 1);

  logic busy, next_busy;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [RAD_W-1:0] rad, next_rad;
  logic [ROOT_W+1:0] rem, next_rem;
  logic [ROOT_W-1:0] root, next_root;
  logic done, next_done;
  logic [ROOT_W+1:0] rem_try;
  logic [ROOT_W+1:0] trial;

  // restoring root: two radicand bits per step
  always_comb begin
    rem_try = {rem[ROOT_W-1:0], rad[RAD_W-1 -: 2]};
    trial = {root, 2'b01};
    next_busy = busy;
    next_cnt = cnt;
    next_rad = rad;
    next_rem = rem;
    next_root = root;
    next_done = 1'b0;
    if (start_in && !busy) begin
      next_busy = 1'b1;
      next_cnt = CNT_W'(ROOT_W);
      next_rad = radicand_in;
      next_rem = '0;
      next_root = '0;
    end else if (busy) begin
      next_rad = {rad[RAD_W-3:0], 2'b00};
      if (rem_try >= trial) begin
        next_rem = rem_try - trial;
        next_root = {root[ROOT_W-2:0], 1'b1};
      end else begin
        next_rem = rem_try;
        next_root = {root[ROOT_W-2:0], 1'b0};
      end
      next_cnt = cnt - CNT_W'(1);
      if (cnt == CNT_W'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      busy <= 1'b0;
      cnt <= '0;
      rad <= '0;
      rem <= '0;
      root <= '0;
      done <= 1'b0;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      rad <= next_rad;
      rem <= next_rem;
      root <= next_root;
      done <= next_done;
    end
  end

  assign done_out = done;
  assign root_out = root;
endmodule : sqrt_iter
`default_nettype wire

// file: bench/fpconv_checker.sv
`default_nettype none
module fpconv_checker (
  input wire logic clk_sys_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic req_valid_in, // request
  input wire logic req_ready_out, // ready
  input wire fpconv_pkg::req_s req_in, // request word
  input wire logic done_out, // done
  input wire fpconv_pkg::result_s result_out, // result
  input wire fpconv_pkg::flags_s flags_out, // flags
  input wire logic [15:0] error_code_register_out, // error code
  input wire logic reg_rd_in, // read strobe
  input wire logic [31:0] reg_rdata_out // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpconv_pkg::*;
  logic take;
  logic neg;
  logic conv;
  req_s last;
  assign take = req_valid_in && req_ready_out;
  assign neg = req_in.wide ? req_in.src_hi[15] : req_in.src_lo[15];
  assign conv = last.op == NUMBER_FORMAT_CONVERT_OP;
  // remembers the request whose completion is awaited
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      last <= '0;
    end else if (take) begin
      last <= req_in;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_conv_done_next: assert property (
    take && req_in.op == NUMBER_FORMAT_CONVERT_OP |=> done_out) else $error("convert late");
  a_root_done_late: assert property (
    take && req_in.op == SQUARE_ROOT_OP && !neg |-> ##18 done_out) else $error("root late");
  a_root_busy: assert property (
    take && req_in.op == SQUARE_ROOT_OP && !neg |=> !req_ready_out [*8]) else $error("busy");
  a_neg_root_error: assert property (
    take && req_in.op == SQUARE_ROOT_OP && neg |=> done_out && flags_out.operation_error_flag
    && flags_out.operation_error_latch && error_code_register_out == ERROR_CODE_NEG_ROOT)
    else $error("negative root not flagged");
  a_neg_root_keep: assert property (
    take && req_in.op == SQUARE_ROOT_OP && neg |=> $stable(result_out)) else $error("written");
  a_zero_match: assert property (
    done_out && !flags_out.operation_error_flag |-> flags_out.zero_flag == (result_out == '0))
    else $error("zero flag wrong");
  a_int_float_range: assert property (
    done_out && conv && !last.conversion_direction_select |->
    !flags_out.carry_overflow_flag && !flags_out.borrow_underflow_flag) else $error("range");
  a_sat_narrow: assert property (
    done_out && conv && last.conversion_direction_select && !last.wide
    && flags_out.carry_overflow_flag |-> result_out.dst_hi == 16'h0000
    && result_out.dst_lo inside {16'h7fff, 16'h8000}) else $error("saturation value");
  a_sat_no_borrow: assert property (
    done_out && conv && last.conversion_direction_select && flags_out.carry_overflow_flag
    |-> !flags_out.borrow_underflow_flag) else $error("borrow on saturation");
  a_rdata_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == '0) else $error("read data outside slot");
endmodule : fpconv_checker

bind sqrt_float_convert_unit fpconv_checker u_checker (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
  .req_in(req_in), .done_out(done_out), .result_out(result_out), .flags_out(flags_out),
  .error_code_register_out(error_code_register_out), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out));
`default_nettype wire

// file: bench/seq_model.sv
`default_nettype none
module seq_model (
  input wire logic clk_in, // clock
  input wire logic req_ready_in, // unit ready
  input wire logic done_in, // completion
  output logic req_valid_out, // request valid
  output fpconv_pkg::req_s req_out // request word
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpconv_pkg::*;
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end
  // called right after a rising edge; lag gives a slow requester
  task automatic run(input req_s r, input int lag, output bit ok);
    int n;
    repeat (lag) @(posedge clk_in);
    req_out <= r;
    req_valid_out <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (req_ready_in !== 1'b1 && n < 50);
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_out <= ~r; // released word no longer shows the request
    ok = 1'b0;
    repeat (40) begin
      @(negedge clk_in);
      if (done_in === 1'b1) begin
        ok = 1'b1;
        break;
      end
    end
    @(posedge clk_in);
  endtask : run
endmodule : seq_model
`default_nettype wire

// file: bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fpconv_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req_valid;
  logic req_ready;
  logic done;
  logic irq;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [15:0] code;
  req_s req;
  result_s res;
  flags_s flg;
  int mismatches = 0;
  int tests_run = 0;
  always #4 clk_sys_in = ~clk_sys_in;

  sqrt_float_convert_unit u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_in(req), .done_out(done),
    .result_out(res), .flags_out(flg), .error_code_register_out(code), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .irq_out(irq));
  seq_model u_seq (.clk_in(clk_sys_in), .req_ready_in(req_ready), .done_in(done),
    .req_valid_out(req_valid), .req_out(req));

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    d = rdata;
    @(posedge clk_sys_in);
  endtask : rd_reg

  task automatic op(input op_e o, input logic w, input logic d, input logic [31:0] s,
                    input int lag);
    bit ok;
    u_seq.run('{op: o, wide: w, conversion_direction_select: d, src_hi: s[31:16],
      src_lo: s[15:0]}, lag, ok);
    chk("done seen", 32'h1, {31'h0, ok});
  endtask : op

  task automatic t_reset;
    @(negedge clk_sys_in);
    chk("reset outputs", 32'h0040_0000, {9'h0, req_ready, irq, flg, code});
    chk("reset result", 32'h0, res);
    @(posedge clk_sys_in);
    $display("test reset done");
  endtask : t_reset

  task automatic t_convert;
    logic [31:0] src[10] = '{32'h0000_000a, 32'h0001_86a0, 32'h0, 32'h0000_ffff,
      32'h47c3_5000, 32'hc7c3_5000, 32'h47c3_5000, 32'h3fc0_0000, 32'h3f00_0000, 32'h4f00_0000};
    logic [31:0] exp[10] = '{32'h4120_0000, 32'h47c3_5000, 32'h0, 32'hbf80_0000,
      32'h0000_7fff, 32'h0000_8000, 32'h0001_86a0, 32'h1, 32'h0, 32'h7fff_ffff};
    logic [4:0] ef[10] = '{5'h0, 5'h0, 5'h1, 5'h0, 5'h4, 5'h4, 5'h0, 5'h2, 5'h3, 5'h4};
    logic [1:0] md[10] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h1, 2'h1, 2'h3};
    for (int i = 0; i < 10; i++) begin
      op(NUMBER_FORMAT_CONVERT_OP, md[i][1], md[i][0], src[i], i % 3);
      chk("convert result", exp[i], res);
      chk("conv flags", {27'h0, ef[i]}, {27'h0, flg});
    end
    $display("test convert done");
  endtask : t_convert

  task automatic t_root;
    logic [31:0] src[4] = '{32'h0000_0090, 32'h0, 32'h7fff_ffff, 32'h0000_0011};
    logic [15:0] exp[4] = '{16'h000c, 16'h0, 16'hb504, 16'h0004};
    for (int i = 0; i < 4; i++) begin
      op(SQUARE_ROOT_OP, i == 2, 1'b0, src[i], i);
      chk("root result", {16'h0, exp[i]}, res);
      chk("root flags", {31'h0, i == 1}, {27'h0, flg});
    end
    $display("test root done");
  endtask : t_root

  task automatic t_neg_root;
    result_s prev;
    for (int i = 0; i < 2; i++) begin
      prev = res;
      op(SQUARE_ROOT_OP, i == 1, 1'b0, i == 1 ? 32'hffff_0001 : 32'h0000_8000, 0);
      chk("negative root result", prev, res);
      chk("negative root flags", 32'h18, {27'h0, flg});
      chk("error code", {16'h0, ERROR_CODE_NEG_ROOT}, {16'h0, code});
    end
    $display("test negative root done");
  endtask : t_neg_root

  task automatic t_regs;
    logic [31:0] d;
    rd_reg(ADDR_FLAGS, d);
    chk("flags register", 32'h18, d);
    wr_reg(ADDR_FLAGS, 32'h10);
    rd_reg(ADDR_FLAGS, d);
    chk("latch cleared", 32'h08, d);
    rd_reg(ADDR_ERROR_CODE, d);
    chk("code register", 32'h0e1b, d);
    wr_reg(ADDR_ERROR_CODE, 32'h0000_0000);
    chk("code written", 32'h0, {16'h0, code});
    rd_reg(ADDR_RESULT, d);
    chk("result register", 32'h4, d);
    rd_reg(8'h20, d);
    chk("unmapped read", 32'h0, d);
    rd_reg(ADDR_IRQ_STATUS, d);
    chk("irq status", 32'h7, d);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr_reg(ADDR_IRQ_MASK, 32'h2);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr_reg(ADDR_IRQ_STATUS, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd_reg(ADDR_IRQ_STATUS, d);
    chk("status after clear", 32'h5, d);
    op(SQUARE_ROOT_OP, 1'b0, 1'b0, 32'h0000_8000, 0);
    @(negedge clk_sys_in);
    chk("irq on new error", 32'h1, {31'h0, irq});
    chk("code reloaded", {16'h0, ERROR_CODE_NEG_ROOT}, {16'h0, code});
    @(posedge clk_sys_in);
    rd_reg(ADDR_IRQ_MASK, d);
    chk("mask register", 32'h2, d);
    wr_reg(ADDR_IRQ_MASK, 32'h0);
    chk("irq unmasked off", 32'h0, {31'h0, irq});
    $display("test registers done");
  endtask : t_regs

  initial begin
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_convert();
    t_root();
    t_neg_root();
    t_regs();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clk_sys_in);
    mismatches++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
